// file: src/ssl_regs.vh
`ifndef SSL_REGS_VH
`define SSL_REGS_VH
// Function codes and the error flag added to the function code of an error reply.
`define SSL_FC_LOOP      8'h08
`define SSL_FC_WRITE     8'h10
`define SSL_FC_ERR_BIT   8'h80
// Slave addresses.
`define SSL_BCAST_ADDR   8'h00
// Register numbers.
`define SSL_REG_NONE     16'h0000
`define SSL_REG_RUN      16'h0001
`define SSL_REG_FREF     16'h0002
`define SSL_REG_VOL_LAST 16'h003D
`define SSL_REG_NV_FIRST 16'h0101
`define SSL_REG_POLICY   16'h01AA
`define SSL_REG_STORE    16'h0900
// Value that must be written to the store trigger.
`define SSL_STORE_KEY    16'h0000
// Store acceptance policy: reset value, stopped-only, any time.
`define SSL_POLICY_RST   1'b0
`define SSL_POLICY_STOP  1'b0
`define SSL_POLICY_MAX   16'h0001
// Frame layout and lengths in bytes.
`define SSL_MAX_REGS     16
`define SSL_LOOP_LEN     6'h08
`define SSL_WR_RSP_LEN   6'h08
`define SSL_ERR_LEN      6'h05
`define SSL_WR_HDR_LEN   7
`define SSL_CRC_LEN      2
`define SSL_MIN_FRAME    6'h04
// CRC-16, reflected form, low byte sent first.
`define SSL_CRC_INIT     16'hFFFF
`define SSL_CRC_POLY     16'hA001
// Error codes sent in the third byte of an error reply.
`define SSL_ERR_FUNC     8'h01
`define SSL_ERR_REG      8'h02
`define SSL_ERR_COUNT    8'h03
`define SSL_ERR_DATA     8'h21
`define SSL_ERR_BUSY     8'h22
`endif

// file: src/ssl_slave.v
// Function
// - A loop-back request is echoed back unchanged and its test data is never acted on.
// - Loop-back request and reply are eight bytes: address, code, two test words, CRC.
// - Loop-back frames count as valid traffic, so they keep the link alive.
// - Errors get a five-byte reply: address, code with top bit, error code, CRC.
// - A write is answered with address, code 10, start register, count and CRC.
// - Every register value travels as a two-byte word, high byte first.
// - A register value is an integer count of its minimum setting unit.
// - Written data goes only to volatile working storage unless stored.
// - Writing 0000 to register 0900 commits received parameters to nonvolatile memory.
// - The commit covers registers 0101 and above; registers up to 003D stay volatile.
// - With policy 0 the store is accepted only when stopped; with 1 always.
// - The policy register sits at 01AA, holds 0 or 1, resets to 0, fixed while running.
// - A write request carries at most sixteen consecutive registers.
// - In a write request the byte count equals twice the register count.
// - Address 00 is broadcast, may write only registers 0001 and 0002, no reply.
`timescale 1ns/1ps
`default_nettype none
`include "ssl_regs.vh"

module ssl_slave #(
  parameter MAX_REGS = `SSL_MAX_REGS
) (
  // Clock and reset.
  input  wire        ref_clk,
  input  wire        nrst,
  // Drive context.
  input  wire [7:0]  slave_addr,
  input  wire        drive_running,
  // Received byte stream; rx_end marks the silence that closes a frame.
  input  wire        rx_valid,
  input  wire [7:0]  rx_data,
  input  wire        rx_end,
  // Transmitted byte stream.
  input  wire        tx_ready,
  output reg         tx_valid,
  output reg  [7:0]  tx_data,
  output reg         tx_last,
  // Volatile working storage write port.
  output reg         wr_en,
  output reg  [15:0] wr_addr,
  output reg  [15:0] wr_data,
  // Nonvolatile commit request and the first register it covers.
  output reg         nv_store,
  output reg  [15:0] nv_first_reg,
  // Link status and settings.
  output reg         comm_alive,
  output reg         store_accept_policy
);

  // Longest legal frame; bytes beyond it are neither counted nor stored, and the frame is then discarded.
  localparam BUF_LEN = `SSL_WR_HDR_LEN + 2 * MAX_REGS + `SSL_CRC_LEN;

  localparam [1:0] S_RX  = 2'b00;
  localparam [1:0] S_CHK = 2'b01;
  localparam [1:0] S_WR  = 2'b10;
  localparam [1:0] S_TX  = 2'b11;

  localparam [1:0] K_ECHO = 2'b00;
  localparam [1:0] K_NORM = 2'b01;
  localparam [1:0] K_ERR  = 2'b10;

  function [15:0] crc16;
    input [15:0] c;
    input [7:0]  d;
    integer      k;
    reg   [15:0] x;
    begin
      x = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1) begin
        if (x[0]) begin
          x = (x >> 1) ^ `SSL_CRC_POLY;
        end else begin
          x = x >> 1;
        end
      end
      crc16 = x;
    end
  endfunction

  reg [7:0]  frame_mem [0:BUF_LEN-1];
  reg [1:0]  state_q;
  reg [5:0]  len_q;
  reg        ovf_q;
  reg [15:0] crc_q;
  reg [4:0]  wr_i_q;
  reg [1:0]  kind_q;
  reg [7:0]  err_q;
  reg [5:0]  tx_i_q;
  reg [5:0]  tx_len_q;
  reg [15:0] tcrc_q;

  wire [7:0]  f_addr  = frame_mem[0];
  wire [7:0]  f_fc    = frame_mem[1];
  wire [15:0] f_start = {frame_mem[2], frame_mem[3]};
  wire [15:0] f_cnt   = {frame_mem[4], frame_mem[5]};
  wire [7:0]  f_bc    = frame_mem[6];
  wire        f_bcast = (f_addr == `SSL_BCAST_ADDR);
  wire        f_mine  = (f_addr == slave_addr) || f_bcast;
  // A CRC run over the whole frame, check bytes included, ends at zero when intact.
  wire        crc_ok  = (crc_q == 16'h0000) && (len_q >= `SSL_MIN_FRAME) && !ovf_q;
  wire [16:0] f_last  = {1'b0, f_start} + {1'b0, f_cnt} - 17'h00001;
  wire [15:0] st_off  = `SSL_REG_STORE - f_start;
  wire [15:0] po_off  = `SSL_REG_POLICY - f_start;
  wire        st_hit  = (f_start <= `SSL_REG_STORE) && (st_off < f_cnt);
  wire        po_hit  = (f_start <= `SSL_REG_POLICY) && (po_off < f_cnt);
  wire [15:0] st_word = {frame_mem[7 + 2 * st_off[3:0]], frame_mem[8 + 2 * st_off[3:0]]};
  wire [15:0] po_word = {frame_mem[7 + 2 * po_off[3:0]], frame_mem[8 + 2 * po_off[3:0]]};
  wire [15:0] cur_reg = f_start + {11'h000, wr_i_q};
  wire [15:0] cur_val = {frame_mem[7 + 2 * wr_i_q], frame_mem[8 + 2 * wr_i_q]};
  // The limit is cut to the width of the count field that it is compared with.
  wire [15:0] cnt_max = MAX_REGS[15:0];

  // Request checks; the error code is zero when the request is acceptable.
  reg [7:0] chk_err;
  always @* begin
    chk_err = 8'h00;
    if (f_fc == `SSL_FC_LOOP) begin
      if (len_q != `SSL_LOOP_LEN) begin
        chk_err = `SSL_ERR_COUNT;
      end
    end else if (f_fc == `SSL_FC_WRITE) begin
      if (f_cnt == 16'h0000 || f_cnt > cnt_max) begin
        chk_err = `SSL_ERR_COUNT;
      end else if ({8'h00, f_bc} != {f_cnt[14:0], 1'b0}) begin
        chk_err = `SSL_ERR_COUNT;
      end else if ({2'b00, len_q} != f_bc + 8'h09) begin
        chk_err = `SSL_ERR_COUNT;
      end else if (f_start == `SSL_REG_NONE || f_last > {1'b0, `SSL_REG_STORE}) begin
        chk_err = `SSL_ERR_REG;
      end else if (f_bcast && (f_start < `SSL_REG_RUN || f_last > {1'b0, `SSL_REG_FREF})) begin
        chk_err = `SSL_ERR_REG;
      end else if (st_hit && st_word != `SSL_STORE_KEY) begin
        chk_err = `SSL_ERR_DATA;
      end else if (st_hit && store_accept_policy == `SSL_POLICY_STOP && drive_running) begin
        chk_err = `SSL_ERR_BUSY;
      end else if (po_hit && drive_running) begin
        chk_err = `SSL_ERR_BUSY;
      end else if (po_hit && po_word > `SSL_POLICY_MAX) begin
        chk_err = `SSL_ERR_DATA;
      end
    end else begin
      chk_err = `SSL_ERR_FUNC;
    end
  end

  // Next byte to send; in normal and error replies the CRC positions are filled from the running transmit CRC.
  reg [7:0] nb;
  always @* begin
    nb = 8'h00;
    case (kind_q)
      K_ECHO: begin
        nb = frame_mem[tx_i_q];
      end
      K_NORM: begin
        if (tx_i_q < 6'h06) begin
          nb = frame_mem[tx_i_q];
        end else if (tx_i_q == 6'h06) begin
          nb = tcrc_q[7:0];
        end else begin
          nb = tcrc_q[15:8];
        end
      end
      K_ERR: begin
        case (tx_i_q)
          6'h00:   nb = frame_mem[0];
          6'h01:   nb = frame_mem[1] | `SSL_FC_ERR_BIT;
          6'h02:   nb = err_q;
          6'h03:   nb = tcrc_q[7:0];
          default: nb = tcrc_q[15:8];
        endcase
      end
      default: begin
        nb = 8'h00;
      end
    endcase
  end

  // Frame capture is kept out of the reset branch so the array maps to plain storage.
  always @(posedge ref_clk) begin
    if (state_q == S_RX && rx_valid && len_q < BUF_LEN) begin
      frame_mem[len_q] <= rx_data;
    end
  end

  always @(posedge ref_clk) begin
    if (!nrst) begin
      state_q             <= S_RX;
      len_q               <= 6'h00;
      ovf_q               <= 1'b0;
      crc_q               <= `SSL_CRC_INIT;
      wr_i_q              <= 5'h00;
      kind_q              <= K_ECHO;
      err_q               <= 8'h00;
      tx_i_q              <= 6'h00;
      tx_len_q            <= 6'h00;
      tcrc_q              <= `SSL_CRC_INIT;
      tx_valid            <= 1'b0;
      tx_data             <= 8'h00;
      tx_last             <= 1'b0;
      wr_en               <= 1'b0;
      wr_addr             <= 16'h0000;
      wr_data             <= 16'h0000;
      nv_store            <= 1'b0;
      nv_first_reg        <= `SSL_REG_NV_FIRST;
      comm_alive          <= 1'b0;
      store_accept_policy <= `SSL_POLICY_RST;
    end else begin
      wr_en      <= 1'b0;
      nv_store   <= 1'b0;
      comm_alive <= 1'b0;
      case (state_q)
        S_RX: begin
          if (rx_valid) begin
            if (len_q < BUF_LEN) begin
              len_q <= len_q + 6'h01;
              crc_q <= crc16(crc_q, rx_data);
            end else begin
              ovf_q <= 1'b1;
            end
          end
          if (rx_end) begin
            state_q <= S_CHK;
          end
        end
        S_CHK: begin
          // Receive state is cleared here, so the next frame always starts at byte zero.
          len_q   <= 6'h00;
          ovf_q   <= 1'b0;
          crc_q   <= `SSL_CRC_INIT;
          tx_i_q  <= 6'h00;
          tcrc_q  <= `SSL_CRC_INIT;
          wr_i_q  <= 5'h00;
          err_q   <= chk_err;
          state_q <= S_RX;
          if (crc_ok && f_mine) begin
            comm_alive <= 1'b1;
            if (chk_err != 8'h00) begin
              kind_q   <= K_ERR;
              tx_len_q <= `SSL_ERR_LEN;
              if (!f_bcast) begin
                state_q <= S_TX;
              end
            end else if (f_fc == `SSL_FC_LOOP) begin
              kind_q   <= K_ECHO;
              tx_len_q <= `SSL_LOOP_LEN;
              if (!f_bcast) begin
                state_q <= S_TX;
              end
            end else begin
              kind_q   <= K_NORM;
              tx_len_q <= `SSL_WR_RSP_LEN;
              state_q  <= S_WR;
            end
          end
        end
        S_WR: begin
          // Values pass through as raw unit counts, high byte first.
          wr_en   <= 1'b1;
          wr_addr <= cur_reg;
          wr_data <= cur_val;
          if (cur_reg == `SSL_REG_POLICY) begin
            store_accept_policy <= cur_val[0];
          end
          if (cur_reg == `SSL_REG_STORE) begin
            // The committer copies from nv_first_reg up, so run and reference stay volatile.
            nv_store <= 1'b1;
          end
          wr_i_q <= wr_i_q + 5'h01;
          if ({11'h000, wr_i_q} == f_cnt - 16'h0001) begin
            state_q <= f_bcast ? S_RX : S_TX;
          end
        end
        S_TX: begin
          // A new byte is loaded only once the sink has taken the one on offer.
          if (!tx_valid || tx_ready) begin
            if (tx_i_q < tx_len_q) begin
              tx_valid <= 1'b1;
              tx_data  <= nb;
              tx_last  <= (tx_i_q == tx_len_q - 6'h01);
              tx_i_q   <= tx_i_q + 6'h01;
              if (tx_i_q < tx_len_q - 6'h02) begin
                tcrc_q <= crc16(tcrc_q, nb);
              end
            end else begin
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
              state_q  <= S_RX;
            end
          end
        end
        default: begin
          state_q <= S_RX;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// file: verification/ssl_slave_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ssl_slave_asserts #(
  parameter MAX_REGS = 16
) (
  // Watched ports of the slave.
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [7:0]  slave_addr,
  input wire logic        drive_running,
  input wire logic        tx_ready,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_last,
  input wire logic        wr_en,
  input wire logic [15:0] wr_addr,
  input wire logic [15:0] wr_data,
  input wire logic        nv_store,
  input wire logic [15:0] nv_first_reg,
  input wire logic        store_accept_policy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [5:0] run_q;
  // Length of the current burst of register writes.
  always_ff @(posedge ref_clk) begin
    run_q <= (!nrst || !wr_en) ? 6'h00 : run_q + 6'h01;
  end
  property p_rst;
    disable iff (1'b0) !nrst |=> !tx_valid && !wr_en && !nv_store;
  endproperty
  a_rst: assert property (p_rst) else $error("activity after reset");
  property p_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_last;
    tx_valid && tx_ready && tx_last |=> !tx_valid;
  endproperty
  a_last: assert property (p_last) else $error("reply overran");
  property p_first;
    $rose(tx_valid) |-> tx_data == slave_addr;
  endproperty
  a_first: assert property (p_first) else $error("reply not addressed");
  property p_nvreg;
    nv_first_reg == 16'h0101;
  endproperty
  a_nvreg: assert property (p_nvreg) else $error("bad commit range");
  property p_store;
    nv_store |-> wr_en && wr_addr == 16'h0900 && wr_data == 16'h0000;
  endproperty
  a_store: assert property (p_store) else $error("bad store");
  property p_pol;
    wr_en && wr_addr == 16'h01AA |=> store_accept_policy == $past(wr_data[0]);
  endproperty
  a_pol: assert property (p_pol) else $error("policy not taken");
  property p_run;
    drive_running && nv_store |-> store_accept_policy;
  endproperty
  a_run: assert property (p_run) else $error("store while running");
  property p_busy;
    drive_running && wr_en |-> wr_addr != 16'h01AA;
  endproperty
  a_busy: assert property (p_busy) else $error("policy changed running");
  property p_burst;
    run_q <= MAX_REGS;
  endproperty
  a_burst: assert property (p_burst) else $error("write burst too long");
endmodule
bind ssl_slave ssl_slave_asserts #(.MAX_REGS(MAX_REGS)) u_ssl_slave_asserts (
  .ref_clk(ref_clk), .nrst(nrst), .slave_addr(slave_addr), .drive_running(drive_running),
  .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
  .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .nv_store(nv_store),
  .nv_first_reg(nv_first_reg), .store_accept_policy(store_accept_policy));
`default_nettype wire

// file: verification/ssl_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module ssl_master_model (
  input wire logic ref_clk,
  input wire logic slow,
  output logic     tx_ready
);
  integer seed = 32'hc848d52b;
  initial tx_ready = 1'b1;
  // When slow, stall at random so every reply byte must be held until taken.
  always @(posedge ref_clk) begin
    tx_ready <= #2 !slow || $random(seed) & 1;
  end
endmodule
`default_nettype wire

// file: verification/serial_slave_loopback_store_bench.sv
`timescale 1ns/1ps
`default_nettype none
module serial_slave_loopback_store_bench;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        drive_running = 1'b0;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_end = 1'b0;
  logic        slow = 1'b0;
  logic        tx_ready, tx_valid, tx_last, wr_en, nv_store, comm_alive, store_accept_policy;
  logic [7:0]  tx_data;
  logic [15:0] wr_addr, wr_data, nv_first_reg;
  logic [31:0] r, wq[$];
  logic [7:0]  f[$], txq[$];
  integer      errors = 0, n_compared = 0, n_store = 0, n_store_exp = 0, n_alive = 0;
  bit          live = 1'b1;
  integer      seed = 32'hc848d52b;
  always #12.5 ref_clk = ~ref_clk;
  ssl_slave u_ssl_slave (.ref_clk(ref_clk), .nrst(nrst), .slave_addr(8'h01),
    .drive_running(drive_running), .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .nv_store(nv_store),
    .nv_first_reg(nv_first_reg), .comm_alive(comm_alive),
    .store_accept_policy(store_accept_policy));
  ssl_master_model u_ssl_master_model (.ref_clk(ref_clk), .slow(slow), .tx_ready(tx_ready));
  task bad(input string m);
    errors++;
    $display("BAD %0t %s", $time, m);
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) bad($sformatf("got %h want %h", s, e));
  endtask
  task end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ q[i];
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task exp(input logic [7:0] q[$]);
    logic [15:0] c;
    c = crc(q);
    txq = {txq, q, c[7:0], c[15:8]};
  endtask
  task er(input logic [7:0] code);
    exp({8'h01, 8'h90, code});
  endtask
  task addc;
    logic [15:0] c;
    c = crc(f);
    f = {f, c[7:0], c[15:8]};
  endtask
  // Drives the frame in f, then waits for every expected result to appear.
  task send;
    integer a0;
    a0 = n_alive;
    foreach (f[j]) begin
      @(posedge ref_clk);
      #2;
      rx_valid = 1'b1;
      rx_data = f[j];
      rx_end = (j == f.size() - 1);
    end
    @(posedge ref_clk);
    #2;
    rx_valid = 1'b0;
    rx_end = 1'b0;
    rx_data = ~rx_data;
    for (int i = 0; i < 600 && txq.size() + wq.size() > 0; i++) @(posedge ref_clk);
    repeat (30) @(posedge ref_clk);
    #2;
    chk(n_alive - a0, live);
    live = 1'b1;
  endtask
  task wrf(input logic [7:0] a, input logic [15:0] st, n, v, input logic [7:0] bx, input bit ok);
    logic [15:0] w, ra;
    f = {a, 8'h10, st[15:8], st[7:0], n[15:8], n[7:0], 8'(n * 2 + bx)};
    for (int i = 0; i < n; i++) begin
      w = v + i;
      ra = st + i;
      f = {f, w[15:8], w[7:0]};
      if (ok) wq.push_back({ra, w});
    end
    if (ok && a != 8'h00) exp({a, 8'h10, st[15:8], st[7:0], n[15:8], n[7:0]});
    if (ok && st == 16'h0900) n_store_exp++;
    addc;
    send;
  endtask
  // Results are taken in the order they appear and matched against the oldest note.
  always @(posedge ref_clk) begin
    if (nrst && tx_valid && tx_ready) begin
      if (txq.size() == 0) bad("unexpected reply byte");
      else begin
        chk(tx_last, txq.size() == 1);
        chk(tx_data, txq.pop_front());
      end
    end
    if (nrst && wr_en) begin
      if (wq.size() == 0) bad("unexpected write");
      else chk({wr_addr, wr_data}, wq.pop_front());
    end
    if (nrst && nv_store) n_store++;
    if (nrst && comm_alive) n_alive++;
  end
  // Whole sequence needs well under 20000 cycles.
  initial begin
    #500000;
    bad("timeout");
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    #2;
    nrst = 1'b1;
    f = '{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37, 8'hDA, 8'h8D};
    txq = f;
    send;
    slow = 1'b1;
    repeat (3) begin
      r = $random(seed);
      f = {8'h01, 8'h08, r[31:24], r[23:16], r[15:8], r[7:0]};
      addc;
      txq = f;
      send;
    end
    f = '{8'h01, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37, 8'hDA, 8'h8C};
    live = 1'b0;
    send;
    f = '{8'h02, 8'h08, 8'h00, 8'h00, 8'hA5, 8'h37};
    addc;
    live = 1'b0;
    send;
    f = '{8'h01, 8'h03, 8'h00, 8'h20, 8'h00, 8'h04};
    addc;
    exp({8'h01, 8'h83, 8'h01});
    send;
    f = '{8'h01, 8'h08, 8'h00, 8'h00, 8'h00};
    addc;
    exp({8'h01, 8'h88, 8'h03});
    send;
    f = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h02, 8'h58,
          8'h63, 8'h39};
    txq = '{8'h01, 8'h10, 8'h00, 8'h01, 8'h00, 8'h02, 8'h10, 8'h08};
    wq = '{32'h00010001, 32'h00020258};
    send;
    wrf(8'h01, 16'h01AA, 1, 1, 0, 1);
    chk(store_accept_policy, 1);
    drive_running = 1'b1;
    wrf(8'h01, 16'h0900, 1, 0, 0, 1);
    er(8'h22);
    wrf(8'h01, 16'h01AA, 1, 0, 0, 0);
    drive_running = 1'b0;
    wrf(8'h01, 16'h01AA, 1, 0, 0, 1);
    chk(store_accept_policy, 0);
    drive_running = 1'b1;
    er(8'h22);
    wrf(8'h01, 16'h0900, 1, 0, 0, 0);
    drive_running = 1'b0;
    er(8'h21);
    wrf(8'h01, 16'h0900, 1, 1, 0, 0);
    wrf(8'h01, 16'h0900, 1, 0, 0, 1);
    er(8'h21);
    wrf(8'h01, 16'h01AA, 1, 2, 0, 0);
    er(8'h02);
    wrf(8'h01, 16'h0000, 1, 5, 0, 0);
    f = '{8'h01, 8'h10, 8'h01, 8'h01, 8'h00, 8'h11, 8'h22, 8'h00, 8'h00};
    addc;
    er(8'h03);
    send;
    live = 1'b0;
    wrf(8'h01, 16'h0101, 17, 0, 0, 0);
    er(8'h03);
    wrf(8'h01, 16'h0101, 2, 0, 1, 0);
    wrf(8'h01, 16'h0101, 16, 16'h1770, 0, 1);
    wrf(8'h00, 16'h0001, 2, 5, 0, 1);
    wrf(8'h00, 16'h0101, 1, 5, 0, 0);
    chk(n_store, n_store_exp);
    chk(txq.size() + wq.size(), 0);
    end_of_test;
  end
endmodule
`default_nettype wire
